// [shared/cdc_map.vh]
// cdc_map.vh: register offsets, field positions, reset values of the comparator control block
// assumes a 32-bit ahb-lite word bus; each register one aligned word
`ifndef CDC_MAP_VH
`define CDC_MAP_VH
`define CDC_OFF_C1_CTRL0   8'h00
`define CDC_OFF_C1_CTRL1   8'h04
`define CDC_OFF_C2_CTRL0   8'h08
`define CDC_OFF_C2_CTRL1   8'h0c
`define CDC_OFF_MIRROR     8'h10
`define CDC_OFF_IRQ_FLAG   8'h14
`define CDC_OFF_IRQ_EN     8'h18
`define CDC_OFF_PORT       8'h1c
`define CDC_OFF_ASEL       8'h20
`define CDC_B_ON           7
`define CDC_B_OUT          6
`define CDC_B_OE           5
`define CDC_B_POL          4
`define CDC_B_SP           2
`define CDC_B_HYS          1
`define CDC_B_SYNC         0
`define CDC_B_INTP         7
`define CDC_B_INTN         6
`define CDC_PCH_HI         5
`define CDC_PCH_LO         4
`define CDC_NCH_HI         2
`define CDC_NCH_LO         0
`define CDC_B_PERIPHERAL_IRQ_EN         0
`define CDC_B_GIE          1
`define CDC_CTRL0_WMASK    8'hb7
`define CDC_CTRL1_WMASK    8'hf7
`define CDC_CTRL0_RST      8'h04
`define CDC_CTRL1_RST      8'h00
`define CDC_PCH_PIN        2'h0
`define CDC_PCH_DAC        2'h1
`define CDC_PCH_FVR        2'h2
`define CDC_PCH_GND        2'h3
`define CDC_NCH_IN1        3'h1
`define CDC_NCH_IN2        3'h2
`define CDC_NCH_IN3        3'h3
`define CDC_NCH_FVR        3'h4
`define CDC_HTRANS_NONSEQ  2'h2
`endif

// [hw/cdc_channel.v]
// cdc_channel.v: one comparator channel: sync, polarity, edges, timer latch, pin path
// assumes raw_cmp async; timer_clk_lvl is the prescaled timer_one clock sampled on hclk
`timescale 1ns/1ps
`default_nettype none
module cdc_channel (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       raw_cmp,
   input  wire       comparator_on,
   input  wire       result_invert,
   input  wire       timer_sync_on,
   input  wire       timer_clk_lvl,
   output wire       compare_result,
   output wire       rise_evt,
   output wire       fall_evt,
   output wire       ext_result
);
   reg sync1_r;
   reg sync2_r;
   reg res_r;
   reg prev_r;
   reg tclk_prev_r;
   reg hold_r;
   wire res_nxt;
   // off comparator reads low; polarity still applies so toggling it makes edges
   assign res_nxt = (sync2_r & comparator_on) ^ result_invert;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r     <= 1'b0;
         sync2_r     <= 1'b0;
         res_r       <= 1'b0;
         prev_r      <= 1'b0;
         tclk_prev_r <= 1'b0;
         hold_r      <= 1'b0;
      end else begin
         sync1_r     <= raw_cmp;
         sync2_r     <= sync1_r;
         res_r       <= res_nxt;
         prev_r      <= res_r;
         tclk_prev_r <= timer_clk_lvl;
         // falling edge of prescaled timer clock; counter uses the rising one, so no race
         if (tclk_prev_r && !timer_clk_lvl) begin
            hold_r <= res_r;
         end
      end
   end
   assign compare_result = res_r;
   assign rise_evt       = res_r & ~prev_r;
   assign fall_evt       = ~res_r & prev_r;
   assign ext_result     = timer_sync_on ? hold_r : res_r;
endmodule // cdc_channel
`default_nettype wire

// [hw/cdc_top.v]
// cdc_top.v: ahb-lite register slave and control for two comparator channels
// assumes analog cores, timer_one and port pads outside; single word transfers
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cdc_map.vh"
module cdc_top (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire [1:0]  raw_cmp,
   input  wire        timer_clk_lvl,
   input  wire [1:0]  pin_direction,
   input  wire [1:0]  port_latch,
   input  wire [7:0]  pin_level,
   output reg  [1:0]  result_pin_out,
   output reg  [1:0]  result_pin_oe_n,
   output reg  [1:0]  timer_gate_result,
   output reg  [1:0]  core_enable,
   output reg  [1:0]  speed_power_sel,
   output reg  [1:0]  hysteresis_on,
   output reg  [7:0]  plus_route,
   output reg  [9:0]  minus_route,
   output reg         irq_req
);
   reg  [7:0]  ctrl0_r [0:1];
   reg  [7:0]  ctrl1_r [0:1];
   reg  [1:0]  irq_flag_r;
   reg  [1:0]  irq_en_r;
   reg  [1:0]  gctl_r;
   reg  [7:0]  asel_r;
   reg         wr_pend_r;
   reg  [7:0]  wr_addr_r;
   reg  [1:0]  flag_nxt;
   reg  [31:0] rd_nxt;
   wire [1:0]  res;
   wire [1:0]  rise;
   wire [1:0]  fall;
   wire [1:0]  ext;
   wire [1:0]  set_evt;
   wire        act;
   wire        flag_wr;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ch
         cdc_channel u_ch (
            .hclk           (hclk),
            .hresetn        (hresetn),
            .raw_cmp        (raw_cmp[g]),
            .comparator_on  (ctrl0_r[g][`CDC_B_ON]),
            .result_invert  (ctrl0_r[g][`CDC_B_POL]),
            .timer_sync_on  (ctrl0_r[g][`CDC_B_SYNC]),
            .timer_clk_lvl  (timer_clk_lvl),
            .compare_result (res[g]),
            .rise_evt       (rise[g]),
            .fall_evt       (fall[g]),
            .ext_result     (ext[g])
         );
         assign set_evt[g] = (rise[g] & ctrl1_r[g][`CDC_B_INTP])
                           | (fall[g] & ctrl1_r[g][`CDC_B_INTN]);
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               result_pin_out[g]    <= 1'b0;
               result_pin_oe_n[g]   <= 1'b1;
               timer_gate_result[g] <= 1'b0;
               core_enable[g]       <= 1'b0;
               speed_power_sel[g]   <= 1'b1;
               hysteresis_on[g]     <= 1'b0;
               plus_route[g*4+3:g*4]  <= 4'h0;
               minus_route[g*5+4:g*5] <= 5'h00;
            end else begin
               // override independent of enable; pad drives only when direction is output
               result_pin_out[g]    <= ctrl0_r[g][`CDC_B_OE] ? ext[g] : port_latch[g];
               result_pin_oe_n[g]   <= pin_direction[g];
               timer_gate_result[g] <= ext[g];
               core_enable[g]       <= ctrl0_r[g][`CDC_B_ON];
               speed_power_sel[g]   <= ctrl0_r[g][`CDC_B_SP];
               hysteresis_on[g]     <= ctrl0_r[g][`CDC_B_HYS];
               // one-hot: pin, dac, fvr, ground; all zero when off
               plus_route[g*4+3:g*4] <= ctrl0_r[g][`CDC_B_ON] ?
                  (4'h1 << ctrl1_r[g][`CDC_PCH_HI:`CDC_PCH_LO]) : 4'h0;
               // one-hot: in1, in2, in3, fvr; reserved codes connect nothing
               case (ctrl1_r[g][`CDC_NCH_HI:`CDC_NCH_LO])
                  `CDC_NCH_IN1: minus_route[g*5+4:g*5] <= {4'h0, ctrl0_r[g][`CDC_B_ON]};
                  `CDC_NCH_IN2: minus_route[g*5+4:g*5] <= {3'h0, ctrl0_r[g][`CDC_B_ON], 1'b0};
                  `CDC_NCH_IN3: minus_route[g*5+4:g*5] <= {2'h0, ctrl0_r[g][`CDC_B_ON], 2'h0};
                  `CDC_NCH_FVR: minus_route[g*5+4:g*5] <= {1'b0, ctrl0_r[g][`CDC_B_ON], 3'h0};
                  default:      minus_route[g*5+4:g*5] <= 5'h10; // reserved flag in top bit
               endcase
            end
         end
      end
   endgenerate

   assign act     = hsel & hready & htrans[1];
   assign flag_wr = wr_pend_r & (wr_addr_r == `CDC_OFF_IRQ_FLAG);

   // plain write of the flag register; set wins over the clear
   always @* begin
      flag_nxt = irq_flag_r;
      if (flag_wr) begin
         flag_nxt = hwdata[1:0];
      end
      flag_nxt = flag_nxt | set_evt;
   end

   always @* begin
      rd_nxt = 32'h0;
      case (haddr[7:0])
         `CDC_OFF_C1_CTRL0: rd_nxt = {24'h0, ctrl0_r[0][7], res[0], ctrl0_r[0][5:0]};
         `CDC_OFF_C1_CTRL1: rd_nxt = {24'h0, ctrl1_r[0]};
         `CDC_OFF_C2_CTRL0: rd_nxt = {24'h0, ctrl0_r[1][7], res[1], ctrl0_r[1][5:0]};
         `CDC_OFF_C2_CTRL1: rd_nxt = {24'h0, ctrl1_r[1]};
         `CDC_OFF_MIRROR:   rd_nxt = {30'h0, res};
         `CDC_OFF_IRQ_FLAG: rd_nxt = {30'h0, irq_flag_r};
         `CDC_OFF_IRQ_EN:   rd_nxt = {28'h0, gctl_r, irq_en_r};
         `CDC_OFF_PORT:     rd_nxt = {24'h0, pin_level & ~asel_r};
         `CDC_OFF_ASEL:     rd_nxt = {24'h0, asel_r};
         default:           rd_nxt = 32'h0;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl0_r[0] <= `CDC_CTRL0_RST;
         ctrl0_r[1] <= `CDC_CTRL0_RST;
         ctrl1_r[0] <= `CDC_CTRL1_RST;
         ctrl1_r[1] <= `CDC_CTRL1_RST;
         irq_flag_r <= 2'h0;
         irq_en_r   <= 2'h0;
         gctl_r     <= 2'h0;
         asel_r     <= 8'h00;
         wr_pend_r  <= 1'b0;
         wr_addr_r  <= 8'h00;
         hrdata     <= 32'h0;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         irq_req    <= 1'b0;
      end else begin
         wr_pend_r  <= act & hwrite;
         wr_addr_r  <= haddr[7:0];
         irq_flag_r <= flag_nxt;
         // reads answer with zero wait states; unmapped reads zero, writes dropped
         if (act && !hwrite) begin
            hrdata <= rd_nxt;
         end
         if (wr_pend_r) begin
            case (wr_addr_r)
               // result bit and bit 3 are not writable
               `CDC_OFF_C1_CTRL0: ctrl0_r[0] <= hwdata[7:0] & `CDC_CTRL0_WMASK;
               `CDC_OFF_C1_CTRL1: ctrl1_r[0] <= hwdata[7:0] & `CDC_CTRL1_WMASK;
               `CDC_OFF_C2_CTRL0: ctrl0_r[1] <= hwdata[7:0] & `CDC_CTRL0_WMASK;
               `CDC_OFF_C2_CTRL1: ctrl1_r[1] <= hwdata[7:0] & `CDC_CTRL1_WMASK;
               `CDC_OFF_IRQ_EN:   {gctl_r, irq_en_r} <= hwdata[3:0];
               `CDC_OFF_ASEL:     asel_r <= hwdata[7:0];
               default:           asel_r <= asel_r;
            endcase
         end
         // request level follows the flags, gated by all three enables
         irq_req <= |(irq_flag_r & irq_en_r) & gctl_r[`CDC_B_PERIPHERAL_IRQ_EN]
                  & gctl_r[`CDC_B_GIE];
      end
   end
endmodule // cdc_top
`default_nettype wire

// [sim/cdc_top_props.sv]
// cdc_top_props.sv: port checker for cdc_top
// assumes one hclk domain; bound at foot
`timescale 1ns/1ps
`default_nettype none
module cdc_top_props (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic [1:0] raw_cmp,
   input wire logic [1:0] pin_direction,
   input wire logic [1:0] result_pin_oe_n,
   input wire logic [1:0] core_enable,
   input wire logic [7:0] plus_route,
   input wire logic [9:0] minus_route,
   input wire logic       irq_req
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic       wr;
   logic [3:0] quiet_r;
   assign wr = hsel && htrans[1] && hwrite;
   // cycles since a write or raw change; saturates so idle never wraps
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
         quiet_r <= 4'hf;
      else if (wr || $changed(raw_cmp))
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
         quiet_r <= quiet_r + 4'h1;
   property p_oe; $stable(pin_direction)[*3] |-> result_pin_oe_n == pin_direction; endproperty
   a_oe: assert property (p_oe) else $error("oe_n differs from direction");
   property p_off1; !core_enable[0] |-> plus_route[3:0] == 4'h0 && minus_route[3:0] == 4'h0; endproperty
   a_off1: assert property (p_off1) else $error("routes live while off");
   property p_off2; core_enable[1] || (plus_route[7:4] == 4'h0 && minus_route[8:5] == 4'h0); endproperty
   a_off2: assert property (p_off2) else $error("routes live while off");
   property p_plus; core_enable[0] |-> $onehot(plus_route[3:0]); endproperty
   a_plus: assert property (p_plus) else $error("plus route not one-hot");
   property p_minus; core_enable[1] |-> $onehot(minus_route[9:5]); endproperty
   a_minus: assert property (p_minus) else $error("minus route not one-hot");
   property p_fall; $fell(irq_req) |-> $past(wr) || $past(wr, 2) || $past(wr, 3); endproperty
   a_fall: assert property (p_fall) else $error("irq dropped without write");
   property p_rise; $rose(irq_req) |-> quiet_r < 4'ha; endproperty
   a_rise: assert property (p_rise) else $error("irq rose without cause");
   // write taken, register updated one edge later, control output one more
   property p_ctl; $changed({core_enable, plus_route}) |-> $past(wr, 3); endproperty
   a_ctl: assert property (p_ctl) else $error("control moved without write");
endmodule // cdc_top_props
bind cdc_top cdc_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .raw_cmp(raw_cmp), .pin_direction(pin_direction),
   .result_pin_oe_n(result_pin_oe_n), .core_enable(core_enable), .plus_route(plus_route),
   .minus_route(minus_route), .irq_req(irq_req));
`default_nettype wire

// [sim/cdc_far_model.sv]
// cdc_far_model.sv: analog comparator cores and timer_one source
// assumes bench sets the analog relation; runs off hclk
`timescale 1ns/1ps
`default_nettype none
module cdc_far_model (
   input  wire logic       hclk,
   input  wire logic [1:0] vp_gt_vn,
   input  wire logic       chatter,
   input  wire logic       tmr_run,
   output var  logic [1:0] raw_cmp,
   output var  logic       timer_clk_lvl
);
   logic [1:0]  div_r = 2'h0;
   logic [15:0] count_r = 16'h0;
   initial raw_cmp = 2'h0;
   initial timer_clk_lvl = 1'b1;
   always @(posedge hclk) begin
      // chatter flips channel 0 every cycle, a worst-case noisy input
      raw_cmp <= chatter ? {vp_gt_vn[1], ~raw_cmp[0]} : vp_gt_vn;
      div_r <= div_r + 2'h1;
      // prescaled clock halts when idle, so a held latch can be seen
      if (tmr_run && div_r == 2'h3)
         timer_clk_lvl <= ~timer_clk_lvl;
   end
   always @(posedge timer_clk_lvl)
      count_r <= count_r + 16'h1;
endmodule // cdc_far_model
`default_nettype wire

// [sim/tb.sv]
// tb.sv: self-checking bench for cdc_top
// assumes cdc_far_model on the analog side
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} cdc_row_t;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        chatter = 1'b0, tmr_run = 1'b0;
   logic [1:0]  pdir = 2'b00;
   logic [1:0]  htrans = 2'h0, vp_gt_vn = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic        hreadyout, hresp, irq_req, timer_clk_lvl;
   logic [1:0]  raw_cmp, pin_out, oe_n, gate, core_en, speed, hys;
   logic [7:0]  plus_route;
   logic [9:0]  minus_route;
   int          errors = 0, num_checks = 0;
   logic [7:0]  ien [5] = '{8'h01, 8'h05, 8'h09, 8'h0c, 8'h0d};
   cdc_row_t    rows [11] = '{'{8'h04, 1, 8'hff, 8'hf7}, '{8'h0c, 1, 8'h6e, 8'h66},
      '{8'h00, 1, 8'h1f, 8'h57}, '{8'h00, 1, 8'h80, 8'h80}, '{8'h08, 1, 8'hff, 8'hf7},
      '{8'h10, 1, 8'hff, 8'h02}, '{8'h14, 0, 8'h00, 8'h01}, '{8'h14, 1, 8'h00, 8'h00},
      '{8'h20, 1, 8'h0f, 8'h0f}, '{8'h1c, 1, 8'hff, 8'h50}, '{8'h28, 1, 8'hff, 8'h00}};
   cdc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .raw_cmp(raw_cmp), .timer_clk_lvl(timer_clk_lvl),
      .pin_direction(pdir), .port_latch(2'b00), .pin_level(8'h5a), .result_pin_out(pin_out),
      .result_pin_oe_n(oe_n), .timer_gate_result(gate), .core_enable(core_en),
      .speed_power_sel(speed), .hysteresis_on(hys), .plus_route(plus_route),
      .minus_route(minus_route), .irq_req(irq_req));
   cdc_far_model u_far (.hclk(hclk), .vp_gt_vn(vp_gt_vn), .chatter(chatter),
      .tmr_run(tmr_run), .raw_cmp(raw_cmp), .timer_clk_lvl(timer_clk_lvl));
   initial forever #5 hclk = ~hclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr_wait(input logic [7:0] a, input logic [7:0] d, input int n);
      bus(a, 1'b1, d);
      repeat (n) @(posedge hclk);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // generous: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge hclk);
      errors++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      bus(8'h00, 1'b0, 8'h00);
      chk({28'h0, speed, core_en}, 32'hc);
      chk(rd, 32'h4);
      foreach (rows[i]) begin
         if (rows[i].w)
            wr_wait(rows[i].a, rows[i].d, 6);
         bus(rows[i].a, 1'b0, 8'h00);
         chk(rd, {24'h0, rows[i].e});
      end
      wr_wait(8'h00, 8'h82, 2);
      chk({26'h0, hys, speed, core_en}, 32'h3b);
      for (int i = 0; i < 5; i++) begin
         wr_wait(8'h04, {4'h0 | i[1:0], 1'b0, i < 4 ? i[2:0] + 3'h1 : 3'h5}, 2);
         chk({minus_route[4:0], plus_route[3:0]}, {5'h1 << i, 4'h1 << i[1:0]});
      end
      wr_wait(8'h00, 8'ha1, 0);
      vp_gt_vn <= 2'b01;
      repeat (8) @(posedge hclk);
      bus(8'h00, 1'b0, 8'h00);
      chk({rd[7:0], gate[0], pin_out[0]}, 10'h384);
      tmr_run <= 1'b1;
      repeat (16) @(posedge hclk);
      tmr_run <= 1'b0;
      wr_wait(8'h00, 8'ha1, 2);
      chk({gate[0], pin_out[0], oe_n[0]}, 3'h6);
      pdir <= 2'b01;
      repeat (2) @(posedge hclk);
      chk({30'h0, oe_n}, 32'h1);
      wr_wait(8'h00, 8'h81, 2);
      chk({31'h0, pin_out[0]}, 32'h0);
      wr_wait(8'h04, 8'hc0, 0);
      chatter <= 1'b1;
      wr_wait(8'h14, 8'h00, 0);
      chatter <= 1'b0;
      // edges reach the flag four edges after the raw input moves
      repeat (6) @(posedge hclk);
      bus(8'h14, 1'b0, 8'h00);
      chk(rd, 32'h1);
      wr_wait(8'h14, 8'h00, 2);
      bus(8'h14, 1'b0, 8'h00);
      chk(rd, 32'h0);
      // polarity flip lands its falling edge in the clearing write's data phase
      wr_wait(8'h00, 8'h91, 0);
      wr_wait(8'h14, 8'h00, 2);
      bus(8'h14, 1'b0, 8'h00);
      chk(rd, 32'h1);
      foreach (ien[i]) begin
         wr_wait(8'h18, ien[i], 3);
         chk({31'h0, irq_req}, {31'h0, ien[i] == 8'h0d});
      end
      wr_wait(8'h14, 8'h00, 3);
      chk({31'h0, irq_req}, 32'h0);
      wr_wait(8'h00, 8'h10, 2);
      chk({minus_route[3:0], plus_route[3:0], core_en}, 10'h2);
      bus(8'h14, 1'b0, 8'h00);
      chk(rd, 32'h1);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({21'h0, hresp, hreadyout, irq_req, oe_n, speed, hys, core_en}, 32'h2f0);
      chk(hrdata, 32'h0);
      hresetn <= 1'b1;
      bus(8'h00, 1'b0, 8'h00);
      chk(rd, 32'h4);
      stop_test;
   end
endmodule // tb
`default_nettype wire
